// ==== dv/acs_far_side.sv ====
// Far-side model: filter output and external conversion clock source
`timescale 1ns/100ps
module acs_far_side
	import acs_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_converting,
	input wire logic i_ext_run,
	input wire logic signed [23:0] i_value,
	output logic signed [23:0] o_filter_value,
	output logic o_ext_pin
);
	logic pin_reg = 1'b0;
	// Value only meaningful during a conversion; inverse outside it
	assign o_filter_value = i_converting ? i_value : ~i_value;
	// Pin toggles every cycle to keep long external counts short; low while stopped
	assign o_ext_pin = pin_reg;
	always @(posedge i_clock)
	begin
		pin_reg <= i_ext_run ? ~pin_reg : 1'b0;
	end
endmodule : acs_far_side

// ==== dv/acs_sequencer_bench.sv ====
// Self-checking bench for the conversion sequencer
`timescale 1ns/100ps
module acs_sequencer_bench
	import acs_pkg::*;
;
	localparam int unsigned L_60_1X = 80;
	localparam int unsigned L_60_2X = 40;
	localparam int unsigned L_50_1X = 96;
	localparam int unsigned L_50_2X = 48;
	localparam int unsigned L_5060_1X = 88;
	localparam int unsigned L_5060_2X = 44;
	// Pin rises every second cycle; start phase moves the end by one cycle
	localparam int unsigned L_EXT_2X_MIN = 2 * 20556 - 1;
	localparam int unsigned L_EXT_2X_MAX = 2 * 20556;
	logic i_clock = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_undervoltage = 1'b0;
	logic ext_pin;
	logic ext_run = 1'b0;
	logic signed [23:0] value = 24'sh001234;
	logic signed [23:0] filter;
	logic [3:0] i_avs_address = 4'h0;
	logic i_avs_read = 1'b0;
	logic i_avs_write = 1'b0;
	logic [31:0] i_avs_writedata = 32'h0;
	logic [31:0] readdata;
	logic waitreq;
	logic [1:0] resp;
	logic ready;
	acs_conv_s conv;
	logic [31:0] rd;
	logic [1:0] rsp;
	int unsigned run = 0;
	int unsigned last_len = 0;
	int unsigned spin = 0;
	logic cal_seen = 1'b0;
	int fail_count = 0;
	int compares = 0;
	logic [6:0] cfgw [6] = '{7'h00, 7'h40, 7'h10, 7'h50, 7'h20, 7'h60};
	int unsigned lens [6] = '{L_5060_1X, L_5060_2X, L_50_1X, L_50_2X, L_60_1X, L_60_2X};
	logic [23:0] vals [4] = '{24'h00FFFF, 24'h010000, 24'hFF0000, 24'hFEFFFF};
	logic [31:0] codes [4] = '{32'h0000FFFF, 32'h00C00000, 32'h00FF0000, 32'h003FFFFF};

	acs_sequencer #(
		.P_CONV_60_1X(L_60_1X), .P_CONV_60_2X(L_60_2X),
		.P_CONV_50_1X(L_50_1X), .P_CONV_50_2X(L_50_2X),
		.P_CONV_5060_1X(L_5060_1X), .P_CONV_5060_2X(L_5060_2X),
		.P_POR(20), .P_EXT_DETECT(50)
	) dut_u (
		.i_clock(i_clock), .i_rst_n(i_rst_n), .i_undervoltage(i_undervoltage),
		.i_address_or_ext_clock_pin(ext_pin), .i_filter_value(filter),
		.i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
		.i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
		.i_avs_byteenable(4'hF), .o_avs_readdata(readdata),
		.o_avs_waitrequest(waitreq), .o_avs_response(resp),
		.o_result_ready(ready), .o_conv(conv)
	);

	acs_far_side far_u (
		.i_clock(i_clock), .i_converting(conv.converting), .i_ext_run(ext_run),
		.i_value(value), .o_filter_value(filter), .o_ext_pin(ext_pin)
	);

	always #2 i_clock = ~i_clock;

	// Conversion length and calibration monitor
	always @(posedge i_clock)
	begin
		if (conv.converting === 1'b1)
			run <= run + 1;
		else if (run != 0)
		begin
			last_len <= run;
			run <= 0;
		end
		if (conv.calibrating === 1'b1 && conv.converting === 1'b1)
			cal_seen <= 1'b1;
	end

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// One Avalon transfer; holds the request until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clock);
		i_avs_address <= a;
		i_avs_write <= wr;
		i_avs_read <= !wr;
		i_avs_writedata <= d;
		do
		begin
			@(posedge i_clock);
			n++;
		end
		while (waitreq !== 1'b0);
		check("bus_latency", n, 32'h2);
		rd = readdata;
		rsp = resp;
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
	endtask : bus

	task automatic wait_on(input string nm, input int sel);
		int n;
		n = 0;
		while ((sel ? conv.converting : ready) !== 1'b1 && n < 1000)
		begin
			@(posedge i_clock);
			n++;
		end
		check(nm, n < 1000, 32'h1);
		repeat (2) @(posedge i_clock);
	endtask : wait_on

	task automatic wrap_up;
		if (fail_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up

	initial
	begin
		#200000;
		fail_count++;
		wrap_up();
	end

	initial
	begin
		repeat (2) @(posedge i_clock);
		i_rst_n <= 1'b1;
		// ****************************************************************
		// Power-on pulse, defaults and automatic first conversion
		// ****************************************************************
		// Undervoltage synchroniser leaves reset high, so the pulse starts late
		repeat (3) @(posedge i_clock);
		bus(1'b0, OFS_STATUS, 32'h0);
		check("status_por", rd, 32'h8);
		bus(1'b0, OFS_CONFIG, 32'h0);
		check("resp_cfg_busy", rsp, RESP_SLVERR);
		check("cfg_default", conv.cfg, 7'h00);
		wait_on("auto_start", 1);
		bus(1'b0, OFS_RESULT, 32'h0);
		check("resp_res_busy", rsp, RESP_SLVERR);
		wait_on("ready_first", 0);
		check("len_default", last_len, L_5060_1X);
		check("cal_seen", cal_seen, 32'h1);
		repeat (10) @(posedge i_clock);
		check("ready_held", ready, 32'h1);
		bus(1'b0, OFS_RESULT, 32'h0);
		check("result_first", rd, 32'h0000_1234);
		check("ready_drop", ready, 32'h0);
		bus(1'b0, OFS_RESULT, 32'h0);
		check("resp_no_repeat", rsp, RESP_SLVERR);
		// ****************************************************************
		// Every rejection and speed setting, every result coding
		// ****************************************************************
		for (int i = 0; i < 6; i++)
		begin
			wait_on("ready_loop", 0);
			value <= vals[i % 4];
			bus(1'b1, OFS_CONFIG, {25'h0, cfgw[i]});
			check("cfg_eff", conv.cfg, cfgw[i]);
			wait_on("ready_cfg", 0);
			check("len_mode", last_len, lens[i]);
			bus(1'b0, OFS_RESULT, 32'h0);
			check("result_code", rd, codes[i % 4]);
		end
		// ****************************************************************
		// Temperature input forces gain one and 1x speed
		// ****************************************************************
		wait_on("ready_temp", 0);
		bus(1'b1, OFS_CONFIG, 32'h5F);
		check("cfg_temp", conv.cfg, 7'h11);
		wait_on("ready_temp2", 0);
		check("len_temp", last_len, L_50_1X);
		bus(1'b1, OFS_CONTROL, 32'h1);
		check("resp_start", rsp, RESP_OKAY);
		check("ready_restart", ready, 32'h0);
		bus(1'b1, OFS_RESULT, 32'h0);
		check("resp_res_write", rsp, RESP_SLVERR);
		bus(1'b0, 4'h2, 32'h0);
		check("resp_unmapped", {rd[29:0], rsp}, {30'h0, RESP_DECERR});
		// ****************************************************************
		// External clock detection
		// ****************************************************************
		wait_on("ready_ext", 0);
		ext_run <= 1'b1;
		repeat (30) @(posedge i_clock);
		bus(1'b0, OFS_STATUS, 32'h0);
		check("status_ext", rd, 32'h6);
		bus(1'b1, OFS_CONFIG, 32'h40);
		check("ext_latched", conv.ext_clock, 32'h1);
		while (ready !== 1'b1 && spin < 50000)
		begin
			@(posedge i_clock);
			spin++;
		end
		check("ready_ext_2x", spin < 50000, 32'h1);
		repeat (2) @(posedge i_clock);
		check("len_ext_2x",
			last_len >= L_EXT_2X_MIN && last_len <= L_EXT_2X_MAX, 32'h1);
		ext_run <= 1'b0;
		repeat (80) @(posedge i_clock);
		bus(1'b0, OFS_STATUS, 32'h0);
		check("status_no_ext", rd, 32'h2);
		// ****************************************************************
		// Undervoltage hold and fresh power-on pulse
		// ****************************************************************
		i_undervoltage <= 1'b1;
		repeat (5) @(posedge i_clock);
		check("uv_ready", ready, 32'h0);
		repeat (30) @(posedge i_clock);
		check("uv_conv", conv.converting, 32'h0);
		i_undervoltage <= 1'b0;
		repeat (5) @(posedge i_clock);
		bus(1'b0, OFS_STATUS, 32'h0);
		check("status_por2", rd, 32'h8);
		check("cfg_cleared", conv.cfg, 7'h00);
		check("ext_cleared", conv.ext_clock, 32'h0);
		wait_on("auto_start2", 1);
		wrap_up();
	end
endmodule : acs_sequencer_bench

// ==== logic/acs_pkg.sv ====
// Constants, types and register map of the conversion sequencer
package acs_pkg;
	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned NS_PER_US = 1000;
	localparam int unsigned T_CONV_60_1X_US = 133000;
	localparam int unsigned T_CONV_60_2X_US = 67000;
	localparam int unsigned T_CONV_50_1X_US = 160000;
	localparam int unsigned T_CONV_50_2X_US = 80000;
	localparam int unsigned T_CONV_5060_1X_US = 147000;
	localparam int unsigned T_CONV_5060_2X_US = 73600;
	localparam int unsigned T_POR_US = 4000;
	// Slowest detectable external clock is 10 kHz
	localparam int unsigned T_EXT_DETECT_US = 100;
	localparam int unsigned CYC_CONV_60_1X = T_CONV_60_1X_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int unsigned CYC_CONV_60_2X = T_CONV_60_2X_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int unsigned CYC_CONV_50_1X = T_CONV_50_1X_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int unsigned CYC_CONV_50_2X = T_CONV_50_2X_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int unsigned CYC_CONV_5060_1X = T_CONV_5060_1X_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int unsigned CYC_CONV_5060_2X = T_CONV_5060_2X_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int unsigned CYC_POR = T_POR_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int unsigned CYC_EXT_DETECT = T_EXT_DETECT_US * NS_PER_US / CLK_PERIOD_NS;
	localparam logic [31:0] EXT_EDGES_1X = 32'h0000_A04C;
	localparam logic [31:0] EXT_EDGES_2X = 32'h0000_504C;
	// Calibration occupies the last eighth of each conversion
	localparam int unsigned CAL_SHIFT = 3;
	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [3:0] OFS_CONFIG = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_RESULT = 4'h8;
	localparam logic [3:0] OFS_CONTROL = 4'hC;
	localparam logic [6:0] CONFIG_RESET = 7'h00;
	localparam int unsigned CTRL_START_BIT = 0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	// ****************************************************************
	// Result coding
	// ****************************************************************
	localparam logic signed [23:0] FULL_SCALE_LIMIT = 24'sh01_0000;
	localparam logic [23:0] RES_OVER = 24'hC0_0000;
	localparam logic [23:0] RES_UNDER = 24'h3F_FFFF;
	localparam logic [2:0] GAIN_ONE = 3'h0;
	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {REJ_5060 = 2'h0, REJ_50 = 2'h1, REJ_60 = 2'h2} acs_rej_e;
	typedef enum logic [1:0] {ST_RESET = 2'h0, ST_POR = 2'h1, ST_CONVERT = 2'h3, ST_READY = 2'h2} acs_state_e;
	typedef struct packed {
		logic speed_2x;
		acs_rej_e rejection;
		logic gain_select_bit2;
		logic gain_select_bit1;
		logic gain_select_bit0;
		logic internal_temperature_input;
	} acs_cfg_s;
	typedef struct packed {
		logic converting;
		logic calibrating;
		logic ext_clock;
		acs_cfg_s cfg;
	} acs_conv_s;
endpackage : acs_pkg

// ==== logic/acs_sequencer.sv ====
// Conversion sequencer with power-on reset, timing and result latch
`timescale 1ns/100ps
module acs_sequencer
	import acs_pkg::*;
#(
	parameter int unsigned P_CONV_60_1X = CYC_CONV_60_1X,
	parameter int unsigned P_CONV_60_2X = CYC_CONV_60_2X,
	parameter int unsigned P_CONV_50_1X = CYC_CONV_50_1X,
	parameter int unsigned P_CONV_50_2X = CYC_CONV_50_2X,
	parameter int unsigned P_CONV_5060_1X = CYC_CONV_5060_1X,
	parameter int unsigned P_CONV_5060_2X = CYC_CONV_5060_2X,
	parameter int unsigned P_POR = CYC_POR,
	parameter int unsigned P_EXT_DETECT = CYC_EXT_DETECT
)
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_undervoltage,
	input wire logic i_address_or_ext_clock_pin,
	input wire logic signed [23:0] i_filter_value,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic [1:0] o_avs_response,
	output logic o_result_ready,
	output acs_conv_s o_conv
);
	// ****************************************************************
	// Pin synchronisers and external clock detect
	// ****************************************************************
	logic uv_meta_reg, uv_sync_reg;
	logic ext_meta_reg, ext_sync_reg, ext_prev_reg;
	logic [31:0] ext_idle_reg, ext_idle_next;
	logic ext_present_reg, ext_present_next;
	logic ext_edge;

	assign ext_edge = ext_sync_reg & ~ext_prev_reg;

	always_comb
	begin
		ext_idle_next = ext_idle_reg;
		ext_present_next = ext_present_reg;
		if (ext_edge)
		begin
			ext_idle_next = 32'h0;
			ext_present_next = 1'b1;
		end
		else if (ext_idle_reg >= 32'(P_EXT_DETECT))
			ext_present_next = 1'b0;
		else
			ext_idle_next = ext_idle_reg + 32'h1;
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			uv_meta_reg <= 1'b1;
			uv_sync_reg <= 1'b1;
			ext_meta_reg <= 1'b0;
			ext_sync_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
			ext_idle_reg <= 32'h0;
			ext_present_reg <= 1'b0;
		end
		else
		begin
			uv_meta_reg <= i_undervoltage;
			uv_sync_reg <= uv_meta_reg;
			ext_meta_reg <= i_address_or_ext_clock_pin;
			ext_sync_reg <= ext_meta_reg;
			ext_prev_reg <= ext_sync_reg;
			ext_idle_reg <= ext_idle_next;
			ext_present_reg <= ext_present_next;
		end
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic acs_cfg_s effective_cfg(input acs_cfg_s c);
		acs_cfg_s e;
		e = c;
		if (c.internal_temperature_input)
		begin
			{e.gain_select_bit2, e.gain_select_bit1, e.gain_select_bit0} = GAIN_ONE;
			e.speed_2x = 1'b0;
		end
		return e;
	endfunction : effective_cfg

	function automatic logic [31:0] conv_length(input acs_cfg_s e, input logic ext);
		logic [31:0] n;
		n = 32'(P_CONV_5060_1X);
		if (ext)
			n = e.speed_2x ? EXT_EDGES_2X : EXT_EDGES_1X;
		else
		begin
			case (e.rejection)
				REJ_60: n = e.speed_2x ? 32'(P_CONV_60_2X) : 32'(P_CONV_60_1X);
				REJ_50: n = e.speed_2x ? 32'(P_CONV_50_2X) : 32'(P_CONV_50_1X);
				default: n = e.speed_2x ? 32'(P_CONV_5060_2X) : 32'(P_CONV_5060_1X);
			endcase
		end
		return n;
	endfunction : conv_length

	function automatic logic [23:0] range_code(input logic signed [23:0] v);
		logic [23:0] r;
		r = v;
		if (v >= FULL_SCALE_LIMIT)
			r = RES_OVER;
		else if (v < -FULL_SCALE_LIMIT)
			r = RES_UNDER;
		return r;
	endfunction : range_code

	// ****************************************************************
	// Sequencer and register file
	// ****************************************************************
	acs_state_e state_reg, state_next;
	acs_cfg_s cfg_reg, cfg_next;
	logic [31:0] cnt_reg, cnt_next;
	logic [31:0] len_reg, len_next;
	logic conv_ext_reg, conv_ext_next;
	logic [23:0] result_reg, result_next;
	logic ready_reg, ready_next;
	logic wait_reg, wait_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] resp_reg, resp_next;
	acs_conv_s conv_reg, conv_next;
	logic req, take, start, tick;

	assign req = i_avs_read | i_avs_write;
	assign take = req & wait_reg;
	assign tick = conv_ext_reg ? ext_edge : 1'b1;

	always_comb
	begin
		state_next = state_reg;
		cfg_next = cfg_reg;
		cnt_next = cnt_reg;
		len_next = len_reg;
		conv_ext_next = conv_ext_reg;
		result_next = result_reg;
		ready_next = ready_reg;
		wait_next = 1'b1;
		rdata_next = rdata_reg;
		resp_next = resp_reg;
		start = 1'b0;
		if (take)
		begin
			wait_next = 1'b0;
			rdata_next = 32'h0;
			resp_next = RESP_OKAY;
			case (i_avs_address)
				OFS_STATUS:
					if (i_avs_read)
						rdata_next = {27'h0, conv_reg.calibrating, state_reg == ST_POR,
							ext_present_reg, ready_reg, state_reg == ST_CONVERT};
				OFS_CONFIG:
					if (state_reg != ST_READY)
						resp_next = RESP_SLVERR;
					else if (i_avs_read)
						rdata_next = {25'h0, cfg_reg};
					else
					begin
						if (i_avs_byteenable[0])
							cfg_next = acs_cfg_s'(i_avs_writedata[6:0]);
						start = 1'b1;
					end
				OFS_RESULT:
					if (state_reg != ST_READY || !i_avs_read)
						resp_next = RESP_SLVERR;
					else
					begin
						rdata_next = {8'h0, result_reg};
						start = 1'b1;
					end
				OFS_CONTROL:
					if (state_reg != ST_READY)
						resp_next = RESP_SLVERR;
					else if (i_avs_write && i_avs_writedata[CTRL_START_BIT])
						start = 1'b1;
				default:
					resp_next = RESP_DECERR;
			endcase
		end
		case (state_reg)
			ST_RESET:
			begin
				state_next = ST_POR;
				cnt_next = 32'(P_POR);
			end
			ST_POR:
				if (cnt_reg <= 32'h1)
					start = 1'b1;
				else
					cnt_next = cnt_reg - 32'h1;
			ST_CONVERT:
				if (tick)
				begin
					if (cnt_reg <= 32'h1)
					begin
						state_next = ST_READY;
						result_next = range_code(i_filter_value);
						ready_next = 1'b1;
					end
					else
						cnt_next = cnt_reg - 32'h1;
				end
			ST_READY:
				;
			default:
				state_next = ST_RESET;
		endcase
		if (start)
		begin
			state_next = ST_CONVERT;
			ready_next = 1'b0;
			conv_ext_next = ext_present_reg;
			len_next = conv_length(effective_cfg(cfg_next), ext_present_reg);
			cnt_next = len_next;
		end
		conv_next.converting = state_next == ST_CONVERT;
		// Calibration slot sits inside the count, so cycle length is unchanged
		conv_next.calibrating = state_next == ST_CONVERT
			&& cnt_next <= (len_next >> CAL_SHIFT);
		conv_next.ext_clock = conv_ext_next;
		conv_next.cfg = effective_cfg(cfg_next);
		if (uv_sync_reg)
		begin
			state_next = ST_RESET;
			cfg_next = CONFIG_RESET;
			cnt_next = 32'h0;
			len_next = 32'h0;
			conv_ext_next = 1'b0;
			ready_next = 1'b0;
			result_next = 24'h0;
			conv_next = '0;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_reg <= ST_RESET;
			cfg_reg <= CONFIG_RESET;
			cnt_reg <= 32'h0;
			len_reg <= 32'h0;
			conv_ext_reg <= 1'b0;
			result_reg <= 24'h0;
			ready_reg <= 1'b0;
			wait_reg <= 1'b1;
			rdata_reg <= 32'h0;
			resp_reg <= RESP_OKAY;
			conv_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			cfg_reg <= cfg_next;
			cnt_reg <= cnt_next;
			len_reg <= len_next;
			conv_ext_reg <= conv_ext_next;
			result_reg <= result_next;
			ready_reg <= ready_next;
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
			resp_reg <= resp_next;
			conv_reg <= conv_next;
		end
	end

	assign o_avs_readdata = rdata_reg;
	assign o_avs_waitrequest = wait_reg;
	assign o_avs_response = resp_reg;
	assign o_result_ready = ready_reg;
	assign o_conv = conv_reg;

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_uv_holds_reset: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		uv_sync_reg |=> state_reg == ST_RESET && !ready_reg)
		else $error("undervoltage did not hold reset");
	a_por_length: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		state_reg == ST_RESET && !uv_sync_reg |=> cnt_reg == 32'(P_POR))
		else $error("power-on pulse length wrong");
	a_por_autostart: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		state_reg == ST_POR && cnt_reg <= 32'h1 && !uv_sync_reg |=> state_reg == ST_CONVERT)
		else $error("no conversion after power-on");
	a_temp_gain_one: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		o_conv.cfg.internal_temperature_input |-> {o_conv.cfg.gain_select_bit2,
			o_conv.cfg.gain_select_bit1, o_conv.cfg.gain_select_bit0} == GAIN_ONE)
		else $error("temperature input without gain one");
	a_temp_speed_1x: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		o_conv.cfg.internal_temperature_input |-> !o_conv.cfg.speed_2x)
		else $error("temperature input at 2x speed");
	a_busy_refused: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		take && i_avs_address == OFS_RESULT && state_reg == ST_CONVERT
		|=> o_avs_response == RESP_SLVERR && !o_avs_waitrequest)
		else $error("result access during conversion accepted");
	a_result_held: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		ready_reg && !start && !uv_sync_reg |=> ready_reg && $stable(result_reg))
		else $error("ready result changed before read");
	a_over_code: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		state_reg == ST_CONVERT && tick && cnt_reg <= 32'h1 && !start && !uv_sync_reg
		&& i_filter_value >= FULL_SCALE_LIMIT |=> result_reg == RES_OVER && ready_reg)
		else $error("overrange code missing");
	a_one_result: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		$rose(ready_reg) |-> $past(state_reg) == ST_CONVERT)
		else $error("result without conversion");
	a_cal_inside: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		o_conv.calibrating |-> o_conv.converting)
		else $error("calibration outside conversion");
	a_default_len: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		state_reg == ST_POR && cnt_reg <= 32'h1 && !uv_sync_reg && !ext_present_reg
		&& cfg_reg == CONFIG_RESET |=> cnt_reg == 32'(P_CONV_5060_1X))
		else $error("default conversion length wrong");
endmodule : acs_sequencer
